// File: include/sfp_pkg.sv
package sfp_pkg;

  localparam int CLK_PERIOD_NS = 8;

  localparam logic [7:0] OP_FAST_READ   = 8'h0B;
  localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE  = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE  = 8'hC7;
  localparam logic [7:0] OP_POWER_DOWN  = 8'hB9;
  localparam logic [7:0] OP_RELEASE     = 8'hAB;
  localparam logic [7:0] OP_WRITE_EN    = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS   = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;

  // Byte counts within one framed instruction, opcode included
  localparam logic [7:0] CNT_OPCODE     = 8'h01;
  localparam logic [7:0] CNT_ADDR_LAST  = 8'h03;
  localparam logic [7:0] CNT_ADDR_DONE  = 8'h04;
  localparam logic [7:0] CNT_PROG_MIN   = 8'h06;
  localparam logic [7:0] CNT_SAT        = 8'hFF;

  localparam int PROG_TIME_NS     = 300000;
  localparam int SECT_TIME_NS     = 1000000;
  localparam int CHIP_TIME_NS     = 4000000;
  localparam int PD_ENTRY_NS      = 3000;
  localparam int RELEASE_NS       = 3000;
  localparam int RELEASE_ID_NS    = 5000;
  localparam int PROG_CYC         = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECT_CYC         = (SECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHIP_CYC         = (CHIP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] PD_CYC  = 32'(PD_ENTRY_NS / CLK_PERIOD_NS);
  localparam logic [31:0] RES_CYC = 32'(RELEASE_NS / CLK_PERIOD_NS);
  localparam logic [31:0] RID_CYC = 32'(RELEASE_ID_NS / CLK_PERIOD_NS);

  localparam logic [3:0] REG_STATUS_OFS  = 4'h0;
  localparam logic [3:0] REG_PROTECT_OFS = 4'h4;
  localparam logic [3:0] REG_ID_OFS      = 4'h8;
  localparam logic [2:0] PROTECT_RST     = 3'h0;

  typedef struct packed {
    logic       pd;
    logic       busy;
    logic       write_enable_latch;
    logic [2:0] bp;
  } sfp_status_t;

  typedef enum logic [3:0] {
    EX_IDLE  = 4'b0001,
    EX_PROG  = 4'b0010,
    EX_ERASE = 4'b0100,
    EX_WAIT  = 4'b1000
  } sfp_exec_t;

  // Serial status byte: busy bit 0, latch bit 1, protect bits 4:2
  function automatic logic [7:0] status_byte(sfp_status_t st);
    return {3'h0, st.bp, st.write_enable_latch, st.busy};
  endfunction

endpackage

// File: hdl/sfp_core.sv
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
module sfp_core
  import sfp_pkg::*;
#(
  parameter int          ADDR_W     = 20,
  parameter int          SECT_W     = 16,
  parameter logic [7:0]  DEVICE_ID  = 8'h5A,  // Arbitrary value
  parameter logic [31:0] PROG_COUNT = 32'(PROG_CYC),
  parameter logic [31:0] SECT_COUNT = 32'(SECT_CYC),
  parameter logic [31:0] CHIP_COUNT = 32'(CHIP_CYC)
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_serial_in,
  output logic             spi_serial_out,
  output logic             spi_serial_out_oe,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output sfp_status_t      status
);

  localparam int NUM_SECT = 1 << (ADDR_W - SECT_W);

  function automatic logic sect_protected(logic [ADDR_W-SECT_W-1:0] sect, logic [2:0] bp);
    int span;
    span = 0;
    if (bp != 3'h0) begin
      span = 1 << (int'(bp) - 1);
    end
    return (bp != 3'h0) && ((int'(sect) + span) >= NUM_SECT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]        mem      [2**ADDR_W];
  logic [7:0]        page_buf [256];
  logic              cs_s1_q, cs_s2_q, cs_s3_q;
  logic              sck_s1_q, sck_s2_q, sck_s3_q;
  logic              si_s1_q, si_s2_q;
  logic              sck_rise, sck_fall, cs_fall, cs_rise;
  logic [2:0]        bit_cnt_q;
  logic [6:0]        rx_q;
  logic [7:0]        rx_byte;
  logic              byte_done;
  logic [7:0]        byte_cnt_q;
  logic [7:0]        opcode_q;
  logic [23:0]       addr_q;
  logic [7:0]        page_off_q;
  logic              accepted_q;
  logic              accept_op;
  logic [7:0]        out_byte_q;
  logic              out_valid_q;
  logic              so_q;
  logic [255:0]      buf_valid_q;
  logic              buf_we;
  logic              end_ok;
  logic              start_prog, start_sect, start_chip;
  logic              go_pd, go_release, wel_set, wel_clr;
  sfp_exec_t         ex_state_q;
  logic [ADDR_W-1:0] walk_q, walk_end_q;
  logic [ADDR_W-9:0] prog_page_q;
  logic [31:0]       timer_q;
  logic              exec_done;
  logic              wel_q;
  logic              pd_q;
  logic              pm_entering_q;
  logic [31:0]       pm_timer_q;
  logic              pm_blocked;
  logic [2:0]        bp_q;
  logic              avs_ack_q;
  logic [31:0]       avs_rdata_q;

  assign status = '{pd: pd_q, busy: (ex_state_q != EX_IDLE), write_enable_latch: wel_q, bp: bp_q};

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges are found between stages two and three
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      si_s1_q  <= 1'b0;
      si_s2_q  <= 1'b0;
    end else begin
      cs_s1_q  <= spi_cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      sck_s1_q <= spi_sclk;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      si_s1_q  <= spi_serial_in;
      si_s2_q  <= si_s1_q;
    end
  end

  assign sck_rise  = sck_s2_q & ~sck_s3_q & ~cs_s2_q;
  assign sck_fall  = ~sck_s2_q & sck_s3_q & ~cs_s2_q;
  assign cs_fall   = ~cs_s2_q & cs_s3_q;
  assign cs_rise   = cs_s2_q & ~cs_s3_q;
  assign rx_byte   = {rx_q, si_s2_q};
  assign byte_done = sck_rise && (bit_cnt_q == 3'h7);

  ////////////////////////////////////////////////////////////////////////////
  // Opcode filter by power state and busy
  assign pm_blocked = pd_q | (pm_timer_q != 32'h0);
  always_comb begin
    if (pm_blocked) begin
      accept_op = (rx_byte == OP_RELEASE) && pd_q && (pm_timer_q == 32'h0);
    end else if (status.busy) begin
      accept_op = (rx_byte == OP_READ_STATUS);
    end else begin
      accept_op = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoder: bit and byte counters, opcode, address, read stream
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_q   <= 3'h0;
      rx_q        <= 7'h00;
      byte_cnt_q  <= 8'h00;
      opcode_q    <= 8'h00;
      addr_q      <= 24'h000000;
      page_off_q  <= 8'h00;
      accepted_q  <= 1'b0;
      out_byte_q  <= 8'h00;
      out_valid_q <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_q   <= 3'h0;
      byte_cnt_q  <= 8'h00;
      accepted_q  <= 1'b0;
      out_valid_q <= 1'b0;
    end else if (cs_rise) begin
      // A stale output flag would drive the pin for a cycle as the next frame opens
      out_valid_q <= 1'b0;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_q      <= rx_byte[6:0];
      if (byte_done) begin
        if (byte_cnt_q != CNT_SAT) begin
          byte_cnt_q <= byte_cnt_q + 8'h01;
        end
        if (byte_cnt_q == 8'h00) begin
          opcode_q   <= rx_byte;
          accepted_q <= accept_op;
          if (rx_byte == OP_READ_STATUS) begin
            out_byte_q  <= status_byte(status);
            out_valid_q <= accept_op;
          end
        end else if (byte_cnt_q <= CNT_ADDR_LAST) begin
          addr_q <= {addr_q[15:0], rx_byte};
          if (byte_cnt_q == CNT_ADDR_LAST) begin
            page_off_q <= rx_byte;
          end
        end
        if (byte_cnt_q != 8'h00) begin
          unique case (opcode_q)
            OP_READ_STATUS: begin
              out_byte_q <= status_byte(status);
            end
            OP_FAST_READ: begin
              // Dummy byte content is never looked at
              if (byte_cnt_q >= CNT_ADDR_DONE) begin
                out_byte_q  <= mem[addr_q[ADDR_W-1:0]];
                out_valid_q <= accepted_q;
                addr_q      <= addr_q + 24'h000001;
              end
            end
            OP_RELEASE: begin
              if (byte_cnt_q >= CNT_ADDR_LAST) begin
                out_byte_q  <= DEVICE_ID;
                out_valid_q <= accepted_q;
              end
            end
            OP_PAGE_PROG: begin
              if (byte_cnt_q >= CNT_ADDR_DONE) begin
                page_off_q <= page_off_q + 8'h01;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shifter: a new bit goes out on each falling edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      so_q <= 1'b0;
    end else if (sck_fall && out_valid_q) begin
      so_q <= out_byte_q[3'h7 - bit_cnt_q];
    end
  end

  assign spi_serial_out    = so_q;
  assign spi_serial_out_oe = ~cs_s2_q & out_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer; a later byte to the same offset overwrites the earlier one
  assign buf_we = byte_done && accepted_q && (opcode_q == OP_PAGE_PROG) &&
                  (byte_cnt_q >= CNT_ADDR_DONE);

  always_ff @(posedge clk) begin
    if (buf_we) begin
      page_buf[page_off_q] <= rx_byte;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_valid_q <= '0;
    end else if (byte_done && (byte_cnt_q == 8'h00) && accept_op &&
                 (rx_byte == OP_PAGE_PROG)) begin
      buf_valid_q <= '0;
    end else if (buf_we) begin
      buf_valid_q[page_off_q] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction execution when select rises on a byte boundary
  assign end_ok = cs_rise && accepted_q && (bit_cnt_q == 3'h0);

  assign start_prog = end_ok && (opcode_q == OP_PAGE_PROG) && wel_q &&
                      (byte_cnt_q >= CNT_PROG_MIN) &&
                      !sect_protected(addr_q[ADDR_W-1:SECT_W], bp_q);
  assign start_sect = end_ok && (opcode_q == OP_SECT_ERASE) && wel_q &&
                      (byte_cnt_q == CNT_ADDR_DONE) &&
                      !sect_protected(addr_q[ADDR_W-1:SECT_W], bp_q);
  assign start_chip = end_ok && (opcode_q == OP_CHIP_ERASE) && wel_q &&
                      (byte_cnt_q == CNT_OPCODE) && (bp_q == 3'h0);
  assign go_pd      = end_ok && (opcode_q == OP_POWER_DOWN) &&
                      (byte_cnt_q == CNT_OPCODE);
  assign go_release = end_ok && (opcode_q == OP_RELEASE) && pd_q;
  assign wel_set    = end_ok && (opcode_q == OP_WRITE_EN) && (byte_cnt_q == CNT_OPCODE);
  assign wel_clr    = (end_ok && (opcode_q == OP_WRITE_DIS) && (byte_cnt_q == CNT_OPCODE)) ||
                      exec_done;

  assign exec_done  = (ex_state_q == EX_WAIT) && (timer_q <= 32'h1);

  // Array walk first, then the full self-timed delay, counted only after the walk
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ex_state_q  <= EX_IDLE;
      walk_q      <= '0;
      walk_end_q  <= '0;
      prog_page_q <= '0;
      timer_q     <= 32'h0;
    end else begin
      unique case (ex_state_q)
        EX_IDLE: begin
          if (start_prog) begin
            ex_state_q  <= EX_PROG;
            walk_q      <= '0;
            prog_page_q <= addr_q[ADDR_W-1:8];
            timer_q     <= PROG_COUNT;
          end else if (start_sect) begin
            ex_state_q <= EX_ERASE;
            walk_q     <= {addr_q[ADDR_W-1:SECT_W], {SECT_W{1'b0}}};
            walk_end_q <= {addr_q[ADDR_W-1:SECT_W], {SECT_W{1'b1}}};
            timer_q    <= SECT_COUNT;
          end else if (start_chip) begin
            ex_state_q <= EX_ERASE;
            walk_q     <= '0;
            walk_end_q <= '1;
            timer_q    <= CHIP_COUNT;
          end
        end
        EX_PROG: begin
          walk_q <= walk_q + 1'b1;
          if (walk_q[7:0] == 8'hFF) begin
            ex_state_q <= EX_WAIT;
          end
        end
        EX_ERASE: begin
          walk_q <= walk_q + 1'b1;
          if (walk_q == walk_end_q) begin
            ex_state_q <= EX_WAIT;
          end
        end
        EX_WAIT: begin
          timer_q <= timer_q - 32'h1;
          if (exec_done) begin
            ex_state_q <= EX_IDLE;
          end
        end
      endcase
    end
  end

  // Programming only clears bits, as a real cell does
  always_ff @(posedge clk) begin
    if ((ex_state_q == EX_PROG) && buf_valid_q[walk_q[7:0]]) begin
      mem[{prog_page_q, walk_q[7:0]}] <= mem[{prog_page_q, walk_q[7:0]}] &
                                         page_buf[walk_q[7:0]];
    end else if (ex_state_q == EX_ERASE) begin
      mem[walk_q] <= ERASED_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write enable latch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wel_q <= 1'b0;
    end else if (wel_set) begin
      wel_q <= 1'b1;
    end else if (wel_clr) begin
      wel_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down entry and release delays share one timer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pd_q          <= 1'b0;
      pm_entering_q <= 1'b0;
      pm_timer_q    <= 32'h0;
    end else if (go_pd && !pm_blocked) begin
      pm_entering_q <= 1'b1;
      pm_timer_q    <= PD_CYC;
    end else if (go_release) begin
      pm_entering_q <= 1'b0;
      pm_timer_q    <= (byte_cnt_q == CNT_OPCODE) ? RES_CYC : RID_CYC;
    end else if (pm_timer_q == 32'h1) begin
      pm_timer_q <= 32'h0;
      pd_q       <= pm_entering_q;
    end else if (pm_timer_q != 32'h0) begin
      pm_timer_q <= pm_timer_q - 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait state on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~avs_ack_q;
  assign avs_readdata    = avs_rdata_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_ack_q   <= 1'b0;
      avs_rdata_q <= 32'h0;
    end else begin
      avs_ack_q <= (avs_read | avs_write) & ~avs_ack_q;
      if (avs_read && !avs_ack_q) begin
        unique case (avs_address)
          REG_STATUS_OFS:  avs_rdata_q <= {26'h0, status};
          REG_PROTECT_OFS: avs_rdata_q <= {29'h0, bp_q};
          REG_ID_OFS:      avs_rdata_q <= {24'h0, DEVICE_ID};
          default:         avs_rdata_q <= 32'h0;
        endcase
      end
    end
  end

  // Protect bits steer erase and program acceptance
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bp_q <= PROTECT_RST;
    end else if (avs_write && avs_ack_q && (avs_address == REG_PROTECT_OFS) &&
                 avs_byteenable[0]) begin
      bp_q <= avs_writedata[2:0];
    end
  end

endmodule
`default_nettype wire

// File: verification/sfp_core_props.sv
`timescale 1ns/10ps
`default_nettype none
module sfp_core_props
  import sfp_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5A
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        spi_cs_n,
  input wire logic        spi_serial_out_oe,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire sfp_status_t status
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  property p_wait_one;
    $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state not one cycle");
  property p_id_read;
    avs_read && !avs_waitrequest && avs_address == 4'h8 |-> avs_readdata == {24'h000000, DEVICE_ID};
  endproperty
  a_id_read: assert property (p_id_read) else $error("id register wrong");
  property p_rd_upper;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
  // Select is synchronised, so the drive may outlive it by a few clocks
  property p_oe_framed;
    spi_serial_out_oe |-> !$past(spi_cs_n, 4);
  endproperty
  a_oe_framed: assert property (p_oe_framed) else $error("output driven outside frame");
  property p_oe_off;
    spi_cs_n [*6] |-> !spi_serial_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output left driven");
  property p_busy_start;
    $rose(status.busy) |-> spi_cs_n && status.write_enable_latch;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("cycle without latch");
  property p_busy_end;
    $fell(status.busy) |-> !status.write_enable_latch;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("latch kept after cycle");
  property p_pd_busy;
    !(status.pd && status.busy);
  endproperty
  a_pd_busy: assert property (p_pd_busy) else $error("busy while powered down");
  property p_pd_entry;
    $rose(status.pd) |-> spi_cs_n && $past(spi_cs_n, 300);
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down entered early");
  property p_pd_exit;
    $fell(status.pd) |-> spi_cs_n && $past(spi_cs_n, 300);
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down left early");
  c_cycle: cover property ($fell(status.busy));
  c_pd: cover property ($rose(status.pd));
  c_release: cover property ($fell(status.pd));
endmodule

bind sfp_core sfp_core_props #(.DEVICE_ID(DEVICE_ID)) sfp_core_props_i (
  .clk               (clk),
  .sys_rst           (sys_rst),
  .spi_cs_n          (spi_cs_n),
  .spi_serial_out_oe (spi_serial_out_oe),
  .avs_address       (avs_address),
  .avs_read          (avs_read),
  .avs_write         (avs_write),
  .avs_readdata      (avs_readdata),
  .avs_waitrequest   (avs_waitrequest),
  .status            (status)
);
`default_nettype wire

// File: verification/sfp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sfp_host_model (
  input  wire logic spi_serial_out,
  input  wire logic spi_serial_out_oe,
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_serial_in
);
  // 125 ns link period, unrelated to the system clock phase
  localparam realtime HALF = 62.5;
  logic saw_oe;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_serial_in = 1'b0;
    saw_oe = 1'b0;
  end
  always @(posedge spi_serial_out_oe) saw_oe = 1'b1;
  task automatic start();
    saw_oe = 1'b0;
    spi_cs_n = 1'b0;
    #HALF;
  endtask
  // Clock idles low; data set while low, read back at the rise
  task automatic xbyte(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    for (int i = 7; i > 7 - nbits; i--) begin
      spi_serial_in = tx[i];
      #HALF;
      spi_sclk = 1'b1;
      // An undriven line reads back inverted so a stale bit cannot pass
      rx[i] = spi_serial_out_oe ? spi_serial_out : ~spi_serial_out;
      #HALF;
      spi_sclk = 1'b0;
    end
  endtask
  // Released data line keeps moving so a stale bit is never mistaken for data
  task automatic stop();
    #HALF;
    spi_cs_n = 1'b1;
    spi_serial_in = ~spi_serial_in;
    #HALF;
  endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sfp_pkg::*;
  localparam logic [7:0] ID = 8'h5A;
  logic        clk;
  logic        sys_rst;
  logic        cs_n, sclk, sdi, sdo, sdo_oe;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  sfp_status_t status;
  int          miscompares;
  int          n_tests;
  logic [7:0]  rxq[$];
  logic [7:0]  txq[$];
  logic [31:0] rd;

  sfp_core #(.ADDR_W(12), .SECT_W(8), .DEVICE_ID(ID), .PROG_COUNT(32'h14),
    .SECT_COUNT(32'h14), .CHIP_COUNT(32'h14)) sfp_core_i (
    .clk(clk), .sys_rst(sys_rst), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_serial_in(sdi), .spi_serial_out(sdo), .spi_serial_out_oe(sdo_oe),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .status(status));
  sfp_host_model sfp_host_model_i (.spi_serial_out(sdo), .spi_serial_out_oe(sdo_oe),
    .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_serial_in(sdi));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic give_up(input string what);
    miscompares++;
    $display("ERROR timeout waiting for %s", what);
    summarize();
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be = 4'hF);
    int k = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (avs_waitrequest !== 1'b0) give_up("bus");
    // Values seen here are those sampled at this rising edge
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // tail: bits sent of the last byte, fewer than 8 breaks the frame on purpose
  task automatic cmd(input logic [7:0] tx[$], input int nrd, input int tail = 8);
    logic [7:0] r;
    rxq = {};
    sfp_host_model_i.start();
    foreach (tx[i]) sfp_host_model_i.xbyte(tx[i], (i == tx.size() - 1) ? tail : 8, r);
    repeat (nrd) begin
      sfp_host_model_i.xbyte(8'h00, 8, r);
      rxq.push_back(r);
    end
    sfp_host_model_i.stop();
    repeat (16) @(posedge clk);
  endtask
  task automatic expect_rx(input logic [7:0] e[$]);
    foreach (e[i]) check("serial byte", {24'h000000, rxq[i]}, {24'h000000, e[i]});
  endtask
  task automatic wait_idle();
    int k = 0;
    while (status.busy !== 1'b0 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k == 20000) give_up("busy");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic s_regs();
    check("status", 32'(status), 32'h0);
    avs(1'b0, 4'h8, 32'h0);
    check("id reg", rd, {24'h000000, ID});
    avs(1'b0, 4'hC, 32'h0);
    check("unmapped", rd, 32'h0);
    avs(1'b1, 4'h4, 32'h7);
    avs(1'b1, 4'h0, 32'hFF);
    avs(1'b0, 4'h0, 32'h0);
    check("status reg", rd, 32'h7);
    avs(1'b1, 4'h4, 32'h0, 4'hE);
    avs(1'b0, 4'h4, 32'h0);
    check("protect lane", rd, 32'h7);
    avs(1'b1, 4'h4, 32'h0);
  endtask
  task automatic s_erase_all();
    cmd('{OP_WRITE_EN}, 0);
    cmd('{OP_READ_STATUS}, 2);
    expect_rx('{8'h02, 8'h02});
    cmd('{OP_CHIP_ERASE}, 0);
    check("chip busy", 32'(status.busy), 32'h1);
    cmd('{OP_READ_STATUS}, 1);
    expect_rx('{8'h03});
    cmd('{OP_RELEASE, 8'h00, 8'h00, 8'h00}, 1);
    check("id while busy", 32'(sfp_host_model_i.saw_oe), 32'h0);
    check("busy kept", 32'(status.busy), 32'h1);
    wait_idle();
    check("chip wel", 32'(status.write_enable_latch), 32'h0);
  endtask
  task automatic s_program();
    txq = '{OP_PAGE_PROG, 8'h00, 8'h00, 8'hFE};
    for (int i = 0; i < 258; i++) txq.push_back(i < 256 ? 8'(i) : 8'(i) ^ 8'h3C);
    cmd('{OP_WRITE_EN}, 0);
    cmd(txq, 0);
    check("prog busy", 32'(status.busy), 32'h1);
    wait_idle();
    check("prog wel", 32'(status.write_enable_latch), 32'h0);
    cmd('{OP_FAST_READ, 8'h00, 8'h00, 8'hFC, 8'hA5}, 6);
    expect_rx('{8'hFE, 8'hFF, 8'h3C, 8'h3D, 8'hFF, 8'hFF});
    cmd('{OP_WRITE_EN}, 0);
    cmd('{OP_PAGE_PROG, 8'h00, 8'h02, 8'h10, 8'hAA, 8'h55}, 0);
    wait_idle();
    cmd('{OP_FAST_READ, 8'h00, 8'h02, 8'h0E, 8'h00}, 5);
    expect_rx('{8'hFF, 8'hFF, 8'hAA, 8'h55, 8'hFF});
  endtask
  task automatic s_protect();
    avs(1'b1, 4'h4, 32'h1);
    cmd('{OP_WRITE_EN}, 0);
    cmd('{OP_WRITE_DIS}, 0);
    check("wel cleared", 32'(status.write_enable_latch), 32'h0);
    cmd('{OP_WRITE_EN}, 0);
    cmd('{OP_SECT_ERASE, 8'h00, 8'h0F, 8'h00}, 0);
    cmd('{OP_CHIP_ERASE}, 0);
    cmd('{OP_PAGE_PROG, 8'h00, 8'h0F, 8'h00, 8'h12, 8'h34}, 0);
    check("protected", {30'h0, status.busy, status.write_enable_latch}, 32'h1);
    cmd('{OP_FAST_READ, 8'h00, 8'h0F, 8'h00, 8'h00}, 1);
    expect_rx('{8'hFF});
    avs(1'b1, 4'h4, 32'h0);
    cmd('{OP_PAGE_PROG, 8'h00, 8'h03, 8'h00, 8'h12, 8'h34, 8'h56}, 0, 4);
    check("partial", {30'h0, status.busy, status.write_enable_latch}, 32'h1);
    cmd('{OP_SECT_ERASE, 8'h00, 8'h02, 8'h00}, 0);
    check("sect busy", 32'(status.busy), 32'h1);
    wait_idle();
    cmd('{OP_FAST_READ, 8'h00, 8'h02, 8'h10, 8'h00}, 2);
    expect_rx('{8'hFF, 8'hFF});
  endtask
  task automatic s_power();
    cmd('{OP_POWER_DOWN}, 0);
    repeat (PD_CYC + 20) @(posedge clk);
    check("pd", 32'(status.pd), 32'h1);
    cmd('{OP_READ_STATUS}, 1);
    check("pd silent", 32'(sfp_host_model_i.saw_oe), 32'h0);
    cmd('{OP_WRITE_EN}, 0);
    check("pd wel", 32'(status.write_enable_latch), 32'h0);
    cmd('{OP_RELEASE}, 0);
    repeat (RES_CYC + 20) @(posedge clk);
    check("released", 32'(status.pd), 32'h0);
    cmd('{OP_RELEASE, 8'h00, 8'h00, 8'h00}, 2);
    expect_rx('{ID, ID});
    cmd('{OP_POWER_DOWN}, 0);
    repeat (PD_CYC + 20) @(posedge clk);
    cmd('{OP_RELEASE, 8'h00, 8'h00, 8'h00}, 1);
    repeat (RES_CYC + 20) @(posedge clk);
    check("id release early", 32'(status.pd), 32'h1);
    repeat (RID_CYC - RES_CYC) @(posedge clk);
    check("id release", 32'(status.pd), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clk);
    give_up("run end");
  end
  initial begin
    sys_rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    miscompares = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    s_regs();
    s_erase_all();
    s_program();
    s_protect();
    s_power();
    summarize();
  end
endmodule
`default_nettype wire
